// ===== smrf_regs.svh
// offsets, field positions, reset values and timing counts of the mode-register file
`ifndef SMRF_REGS_SVH
`define SMRF_REGS_SVH

// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define SMRF_ADDR_DEVICE_INFO_FLAGS 6'h00
`define SMRF_ADDR_BURST_PREAMBLE_CONFIG 6'h01
`define SMRF_ADDR_LATENCY_CONFIG 6'h02
`define SMRF_ADDR_IO_CONFIG 6'h03
`define SMRF_ADDR_REFRESH_TRAINING_CTRL 6'h04
`define SMRF_ADDR_MAKER_CODE 6'h05
`define SMRF_ADDR_REVISION_ONE 6'h06
`define SMRF_ADDR_REVISION_TWO 6'h07
`define SMRF_ADDR_GEOMETRY_INFO 6'h08
`define SMRF_ADDR_VENDOR_TEST 6'h09
`define SMRF_ADDR_IMPEDANCE_CAL_CTRL 6'h0a
`define SMRF_ADDR_TERMINATION_CTRL 6'h0b
`define SMRF_ADDR_CA_REFERENCE_LEVEL 6'h0c
`define SMRF_ADDR_SET_POINT_CONTROL 6'h0d
`define SMRF_ADDR_DQ_REFERENCE_LEVEL 6'h0e
`define SMRF_ADDR_LOW_BYTE_INVERT_MASK 6'h0f
`define SMRF_ADDR_BANK_RETENTION_MASK 6'h10
`define SMRF_ADDR_SEGMENT_RETENTION_MASK 6'h11
`define SMRF_ADDR_OSC_COUNT_LOW 6'h12
`define SMRF_ADDR_OSC_COUNT_HIGH 6'h13
`define SMRF_ADDR_HIGH_BYTE_INVERT_MASK 6'h14
`define SMRF_ADDR_VENDOR_RESERVED 6'h15
`define SMRF_ADDR_TERMINATION_FEATURE_TWO 6'h16
`define SMRF_ADDR_OSC_RUN_TIME 6'h17
`define SMRF_ADDR_LAST 6'h17

// ------------------------------------------------------------
// field positions and writable masks
// ------------------------------------------------------------
`define SMRF_LATENCY_WRLEV_BIT 7
`define SMRF_TERM_CMD_LSB 4
`define SMRF_TERM_DATA_LSB 0
`define SMRF_TERM_MASK 8'h77
`define SMRF_REF_LEVEL_MASK 8'h7f
`define SMRF_INFO_MASK 8'h1f
`define SMRF_IMP_CAL_MASK 8'h01

// ------------------------------------------------------------
// reset values and undefined read pattern
// ------------------------------------------------------------
`define SMRF_RESET_VALUE 8'h00
`define SMRF_REF_LEVEL_RESET 8'h4d
`define SMRF_UNDEF_READ 8'h00

// ------------------------------------------------------------
// timing: read answer latency
// ------------------------------------------------------------
`define SMRF_READ_LATENCY 2'h2

`endif

// ===== smrf_pkg.sv
// types of the mode-register file
package smrf_pkg;

  typedef enum logic [1:0] {
    SMRF_CLS_NONE = 2'h0,
    SMRF_CLS_RO = 2'h1,
    SMRF_CLS_WO = 2'h2,
    SMRF_CLS_RW = 2'h3
  } smrf_class_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] data;
  } smrf_cmd_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } smrf_rsp_type;

  typedef struct packed {
    logic [7:0] burst_preamble;
    logic [7:0] latency;
    logic [7:0] io;
    logic [7:0] refresh;
    logic [3:0] cmd_termination;
    logic [3:0] data_termination;
    logic [7:0] set_point;
    logic [7:0] low_byte_invert;
    logic [7:0] high_byte_invert;
    logic write_leveling;
  } smrf_cfg_type;

  typedef enum logic [1:0] {
    SMRF_ST_IDLE = 2'b00,
    SMRF_ST_READ = 2'b01,
    SMRF_ST_ANSWER = 2'b11
  } smrf_state_type;

endpackage

// ===== smrf_store.sv
// small register store with registered read data
`timescale 1ns/1ps
module smrf_store
  import smrf_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [5:0] rd_addr,
  output logic [7:0] rd_data
);
  `include "smrf_regs.svh"

  logic [7:0] mem_reg [0:23];

  // ------------------------------------------------------------
  // storage per entry
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 24; gi = gi + 1) begin : g_entry
      always_ff @(posedge clk) begin
        if (srst) begin
          mem_reg[gi] <= `SMRF_RESET_VALUE;
        end else if (wr_en && wr_addr == 6'(gi)) begin
          mem_reg[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // registered read
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= `SMRF_RESET_VALUE;
    end else if (rd_addr <= `SMRF_ADDR_LAST) begin
      rd_data <= mem_reg[rd_addr[4:0]];
    end else begin
      rd_data <= `SMRF_UNDEF_READ;
    end
  end
endmodule

// ===== smrf_outz.sv
// output-enable gate that releases data pins while clock enable is low
`timescale 1ns/1ps
module smrf_outz
  import smrf_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic cke_sync,
  input wire logic drive_req,
  input wire logic [7:0] drive_data,
  output logic [7:0] dq_out,
  output logic dq_oe
);
  `include "smrf_regs.svh"

  // ------------------------------------------------------------
  // drive only while clock enable is high
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      dq_oe <= 1'b0;
      dq_out <= `SMRF_RESET_VALUE;
    end else begin
      dq_oe <= drive_req && cke_sync;
      dq_out <= drive_data;
    end
  end
endmodule

// ===== smrf_top.sv
// mode-register file of a low-power sdram channel with read and write service
// Behaviour
// - data outputs stay released while clock enable is low; the synchroniser lets them drive up to two cycles after it falls.
// - each register is read-only, write-only or read/write by class.
// - read command returns the addressed register; write command updates it.
// - address 00h reports device capability and resistor self-test result, read-only.
// - address 01h write-only burst, preamble, recovery and postamble settings.
// - address 03h write-only inversion, drive, repair, postamble, calibration.
// - address 04h read/write flag, offset, repair, abort and refresh rate.
// - address 08h read-only io width, density and type.
// - address 0Bh write-only command and data termination, rest reserved.
// - address 14h write-only high byte calibration inversion mask.
// - bit 7 of latency config enters write leveling; zero leaves it.
// - reserved bits written zero by controller, read back as zero.
// - reading write-only or reserved register returns undefined data.
// - writes to read-only registers change nothing.
`timescale 1ns/1ps
module smrf_top
  import smrf_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic cke,
  input wire smrf_cmd_type cmd,
  input wire logic [4:0] info_flags,
  input wire logic [7:0] geometry,
  input wire logic [7:0] osc_count_lo,
  input wire logic [7:0] osc_count_hi,
  input wire logic [7:0] refresh_status,
  output smrf_rsp_type rsp,
  output smrf_cfg_type cfg,
  output logic [7:0] dq_out,
  output logic dq_oe
);
  `include "smrf_regs.svh"

  parameter logic [7:0] MAKER_VALUE = 8'h5a; // arbitrary value
  parameter logic [7:0] REVISION_ONE_VALUE = 8'h01; // arbitrary value
  parameter logic [7:0] REVISION_TWO_VALUE = 8'h02; // arbitrary value

  // ------------------------------------------------------------
  // clock enable synchroniser
  // ------------------------------------------------------------
  logic cke_meta_reg;
  logic cke_sync_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      cke_meta_reg <= 1'b0;
      cke_sync_reg <= 1'b0;
    end else begin
      cke_meta_reg <= cke;
      cke_sync_reg <= cke_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // access class decode
  // ------------------------------------------------------------
  function automatic smrf_class_type class_of(input logic [5:0] a);
    smrf_class_type c;
    c = SMRF_CLS_NONE;
    unique case (a)
      `SMRF_ADDR_DEVICE_INFO_FLAGS,
      `SMRF_ADDR_MAKER_CODE,
      `SMRF_ADDR_REVISION_ONE,
      `SMRF_ADDR_REVISION_TWO,
      `SMRF_ADDR_GEOMETRY_INFO,
      `SMRF_ADDR_OSC_COUNT_LOW,
      `SMRF_ADDR_OSC_COUNT_HIGH: c = SMRF_CLS_RO;
      `SMRF_ADDR_REFRESH_TRAINING_CTRL,
      `SMRF_ADDR_CA_REFERENCE_LEVEL,
      `SMRF_ADDR_DQ_REFERENCE_LEVEL: c = SMRF_CLS_RW;
      default: c = (a <= `SMRF_ADDR_LAST) ? SMRF_CLS_WO : SMRF_CLS_NONE;
    endcase
    return c;
  endfunction

  // reserved bits forced to zero on write
  function automatic logic [7:0] wmask_of(input logic [5:0] a);
    logic [7:0] m;
    m = 8'hff;
    unique case (a)
      `SMRF_ADDR_TERMINATION_CTRL: m = `SMRF_TERM_MASK;
      `SMRF_ADDR_CA_REFERENCE_LEVEL,
      `SMRF_ADDR_DQ_REFERENCE_LEVEL: m = `SMRF_REF_LEVEL_MASK;
      `SMRF_ADDR_IMPEDANCE_CAL_CTRL: m = `SMRF_IMP_CAL_MASK;
      `SMRF_ADDR_VENDOR_RESERVED: m = 8'h00;
      default: m = 8'hff;
    endcase
    return m;
  endfunction

  smrf_class_type cls;
  logic wr_ok;
  logic rd_ok;
  logic [7:0] wr_value;
  always_comb begin
    cls = class_of(cmd.addr);
    wr_ok = cmd.wr && (cls == SMRF_CLS_WO || cls == SMRF_CLS_RW);
    rd_ok = cls == SMRF_CLS_RO || cls == SMRF_CLS_RW;
    wr_value = cmd.data & wmask_of(cmd.addr);
  end

  // ------------------------------------------------------------
  // register store
  // ------------------------------------------------------------
  logic [7:0] store_rd;
  smrf_store u_store (
    .clk(clk),
    .srst(srst),
    .wr_en(wr_ok),
    .wr_addr(cmd.addr),
    .wr_data(wr_value),
    .rd_addr(cmd.addr),
    .rd_data(store_rd)
  );

  // ------------------------------------------------------------
  // configuration outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg <= '0;
    end else if (wr_ok) begin
      unique case (cmd.addr)
        `SMRF_ADDR_BURST_PREAMBLE_CONFIG: cfg.burst_preamble <= wr_value;
        `SMRF_ADDR_LATENCY_CONFIG: begin
          cfg.latency <= wr_value;
          cfg.write_leveling <= wr_value[`SMRF_LATENCY_WRLEV_BIT];
        end
        `SMRF_ADDR_IO_CONFIG: cfg.io <= wr_value;
        `SMRF_ADDR_REFRESH_TRAINING_CTRL: cfg.refresh <= wr_value;
        `SMRF_ADDR_TERMINATION_CTRL: begin
          cfg.cmd_termination <= wr_value[`SMRF_TERM_CMD_LSB +: 4];
          cfg.data_termination <= wr_value[`SMRF_TERM_DATA_LSB +: 4];
        end
        `SMRF_ADDR_SET_POINT_CONTROL: cfg.set_point <= wr_value;
        `SMRF_ADDR_LOW_BYTE_INVERT_MASK: cfg.low_byte_invert <= wr_value;
        `SMRF_ADDR_HIGH_BYTE_INVERT_MASK: cfg.high_byte_invert <= wr_value;
        default: cfg <= cfg;
      endcase
    end
  end

  // ------------------------------------------------------------
  // read sequencer
  // ------------------------------------------------------------
  smrf_state_type state_reg;
  logic [5:0] raddr_reg;
  logic rd_ok_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= SMRF_ST_IDLE;
      raddr_reg <= 6'h00;
      rd_ok_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        SMRF_ST_IDLE: begin
          if (cmd.rd && !cmd.wr) begin
            state_reg <= SMRF_ST_READ;
            raddr_reg <= cmd.addr;
            rd_ok_reg <= rd_ok;
          end
        end
        SMRF_ST_READ: state_reg <= SMRF_ST_ANSWER;
        SMRF_ST_ANSWER: state_reg <= SMRF_ST_IDLE;
        default: state_reg <= SMRF_ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // read value selection
  // ------------------------------------------------------------
  logic [7:0] read_value;
  always_comb begin
    unique case (raddr_reg)
      `SMRF_ADDR_DEVICE_INFO_FLAGS: read_value = {3'h0, info_flags} & `SMRF_INFO_MASK;
      `SMRF_ADDR_MAKER_CODE: read_value = MAKER_VALUE;
      `SMRF_ADDR_REVISION_ONE: read_value = REVISION_ONE_VALUE;
      `SMRF_ADDR_REVISION_TWO: read_value = REVISION_TWO_VALUE;
      `SMRF_ADDR_GEOMETRY_INFO: read_value = geometry;
      `SMRF_ADDR_OSC_COUNT_LOW: read_value = osc_count_lo;
      `SMRF_ADDR_OSC_COUNT_HIGH: read_value = osc_count_hi;
      `SMRF_ADDR_REFRESH_TRAINING_CTRL: read_value = (store_rd & 8'h78) | (refresh_status & 8'h87);
      default: read_value = store_rd;
    endcase
    if (!rd_ok_reg) begin
      read_value = `SMRF_UNDEF_READ;
    end
  end

  // ------------------------------------------------------------
  // answer and pin drive
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp <= '0;
    end else begin
      rsp.valid <= state_reg == SMRF_ST_READ;
      rsp.data <= (state_reg == SMRF_ST_READ) ? read_value : 8'h00;
    end
  end

  smrf_outz u_outz (
    .clk(clk),
    .srst(srst),
    .cke_sync(cke_sync_reg),
    .drive_req(state_reg == SMRF_ST_READ),
    .drive_data(read_value),
    .dq_out(dq_out),
    .dq_oe(dq_oe)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_OE_CKE: assert property (@(posedge clk) disable iff (srst)
    !cke_sync_reg |=> !dq_oe) else $error("data pins driven while clock enable low");

  AST_READ_ANSWER: assert property (@(posedge clk) disable iff (srst)
    (state_reg == SMRF_ST_IDLE && cmd.rd && !cmd.wr) |-> ##2 rsp.valid)
    else $error("read not answered in two cycles");

  AST_RO_PROTECT: assert property (@(posedge clk) disable iff (srst)
    (cmd.wr && class_of(cmd.addr) == SMRF_CLS_RO) |-> !wr_ok ##1 cfg == $past(cfg))
    else $error("write accepted on read-only register");

  AST_WRLEV: assert property (@(posedge clk) disable iff (srst)
    (wr_ok && cmd.addr == `SMRF_ADDR_LATENCY_CONFIG) |=> cfg.write_leveling == $past(cmd.data[7]))
    else $error("write leveling not following latency bit 7");

  AST_TERM_SPLIT: assert property (@(posedge clk) disable iff (srst)
    (wr_ok && cmd.addr == `SMRF_ADDR_TERMINATION_CTRL) |=>
      cfg.cmd_termination == {1'b0, $past(cmd.data[6:4])} &&
      cfg.data_termination == {1'b0, $past(cmd.data[2:0])})
    else $error("termination fields wrong");

  AST_WO_UNDEF: assert property (@(posedge clk) disable iff (srst)
    (state_reg == SMRF_ST_IDLE && cmd.rd && !cmd.wr && class_of(cmd.addr) == SMRF_CLS_WO)
      |-> ##2 rsp.data == `SMRF_UNDEF_READ)
    else $error("write-only read returned data");

  AST_INFO_RSVD: assert property (@(posedge clk) disable iff (srst)
    (state_reg == SMRF_ST_IDLE && cmd.rd && !cmd.wr && cmd.addr == `SMRF_ADDR_DEVICE_INFO_FLAGS)
      |-> ##2 rsp.data[7:5] == 3'h0)
    else $error("reserved info bits not zero");

  AST_LOW_MASK: assert property (@(posedge clk) disable iff (srst)
    (wr_ok && cmd.addr == `SMRF_ADDR_LOW_BYTE_INVERT_MASK) |=>
      cfg.low_byte_invert == $past(cmd.data))
    else $error("low byte mask not stored");

  AST_HIGH_MASK: assert property (@(posedge clk) disable iff (srst)
    (wr_ok && cmd.addr == `SMRF_ADDR_HIGH_BYTE_INVERT_MASK) |=>
      cfg.high_byte_invert == $past(cmd.data))
    else $error("high byte mask not stored");

  AST_VALID_PULSE: assert property (@(posedge clk) disable iff (srst)
    rsp.valid |=> !rsp.valid) else $error("answer longer than one cycle");

  AST_BURST_CFG: assert property (@(posedge clk) disable iff (srst)
    (wr_ok && cmd.addr == `SMRF_ADDR_BURST_PREAMBLE_CONFIG) |=>
      cfg.burst_preamble == $past(cmd.data))
    else $error("burst settings not stored");

  AST_LATENCY_CFG: assert property (@(posedge clk) disable iff (srst)
    (wr_ok && cmd.addr == `SMRF_ADDR_LATENCY_CONFIG) |=>
      cfg.latency == $past(cmd.data))
    else $error("latency settings not stored");

  AST_IO_CFG: assert property (@(posedge clk) disable iff (srst)
    (wr_ok && cmd.addr == `SMRF_ADDR_IO_CONFIG) |=>
      cfg.io == $past(cmd.data))
    else $error("io settings not stored");

  AST_REFRESH_CFG: assert property (@(posedge clk) disable iff (srst)
    (wr_ok && cmd.addr == `SMRF_ADDR_REFRESH_TRAINING_CTRL) |=>
      cfg.refresh == $past(cmd.data))
    else $error("refresh settings not stored");

  AST_SET_POINT: assert property (@(posedge clk) disable iff (srst)
    (wr_ok && cmd.addr == `SMRF_ADDR_SET_POINT_CONTROL) |=>
      cfg.set_point == $past(cmd.data))
    else $error("set-point settings not stored");

  AST_UNMAPPED_WR: assert property (@(posedge clk) disable iff (srst)
    (cmd.wr && cmd.addr > `SMRF_ADDR_LAST) |=>
      cfg == $past(cfg))
    else $error("write outside register space changed settings");

  AST_REF_RSVD: assert property (@(posedge clk) disable iff (srst)
    (state_reg == SMRF_ST_IDLE && cmd.rd && !cmd.wr && cmd.addr == `SMRF_ADDR_CA_REFERENCE_LEVEL)
      |-> ##2 rsp.data[7] == 1'b0)
    else $error("reserved reference bit not zero");

  AST_INFO_VALUE: assert property (@(posedge clk) disable iff (srst)
    (state_reg == SMRF_ST_IDLE && cmd.rd && !cmd.wr && cmd.addr == `SMRF_ADDR_DEVICE_INFO_FLAGS)
      |-> ##2 rsp.data[4:0] == $past(info_flags))
    else $error("device info not reported");

  AST_GEOMETRY: assert property (@(posedge clk) disable iff (srst)
    (state_reg == SMRF_ST_IDLE && cmd.rd && !cmd.wr && cmd.addr == `SMRF_ADDR_GEOMETRY_INFO)
      |-> ##2 rsp.data == $past(geometry))
    else $error("geometry not reported");

  AST_OSC_VALUE: assert property (@(posedge clk) disable iff (srst)
    (state_reg == SMRF_ST_IDLE && cmd.rd && !cmd.wr && cmd.addr == `SMRF_ADDR_OSC_COUNT_LOW)
      |-> ##2 rsp.data == $past(osc_count_lo))
    else $error("oscillator count not reported");

  AST_DQ_MATCH: assert property (@(posedge clk) disable iff (srst)
    dq_oe |->
      dq_out == rsp.data)
    else $error("pin data differs from answer");

  AST_OE_ANSWER: assert property (@(posedge clk) disable iff (srst)
    dq_oe |->
      rsp.valid)
    else $error("data pins driven outside answer");

  AST_WR_NO_ANSWER: assert property (@(posedge clk) disable iff (srst)
    (state_reg == SMRF_ST_IDLE && cmd.rd && cmd.wr) |->
      ##2 !rsp.valid)
    else $error("combined request answered as read");

  AST_CFG_HOLD: assert property (@(posedge clk) disable iff (srst)
    !cmd.wr |=>
      cfg == $past(cfg))
    else $error("settings changed without write");

  AST_RSP_IDLE_ZERO: assert property (@(posedge clk) disable iff (srst)
    !rsp.valid |->
      rsp.data == 8'h00)
    else $error("answer data outside answer cycle");

  AST_BUSY_IGNORE: assert property (@(posedge clk) disable iff (srst)
    state_reg != SMRF_ST_IDLE |=>
      state_reg != SMRF_ST_READ)
    else $error("read taken while busy");
endmodule

// ===== smrf_ctrl_model.sv
// controller-side model issuing mode register commands and clock enable
`timescale 1ns/1ps
module smrf_ctrl_model
  import smrf_pkg::*;
(
  input wire logic clk,
  output smrf_cmd_type cmd,
  output logic cke
);
  initial begin
    cmd = '0;
    cke = 1'b0;
  end

  // ------------------------------------------------------------
  // request driving
  // ------------------------------------------------------------
  // request held n cycles, then released with rd and wr low and address and data inverted
  task automatic issue(input logic rd, input logic wr, input logic [5:0] a,
                       input logic [7:0] d, input int n);
    @(negedge clk);
    cmd <= '{rd: rd, wr: wr, addr: a, data: d};
    repeat (n) @(negedge clk);
    cmd <= '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~d};
  endtask

  // clock enable stays where set until told otherwise
  task automatic set_cke(input logic v);
    @(negedge clk);
    cke <= v;
  endtask
endmodule

// ===== testbench.sv
// self-checking bench of the mode-register file
`timescale 1ns/1ps
`include "smrf_regs.svh"
module testbench;
  import smrf_pkg::*;
  localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
  localparam logic [7:0] REV1 = 8'h11; // arbitrary value
  localparam logic [7:0] REV2 = 8'h22; // arbitrary value
  logic clk;
  logic srst;
  smrf_cmd_type cmd;
  logic cke;
  logic [4:0] info_flags;
  logic [7:0] geometry;
  logic [7:0] osc_lo;
  logic [7:0] osc_hi;
  logic [7:0] refresh_status;
  smrf_rsp_type rsp;
  smrf_cfg_type cfg;
  smrf_cfg_type cfg_seen;
  logic [7:0] dq_out;
  logic dq_oe;
  logic [7:0] shadow [0:63];
  logic [5:0] ra;
  int miscompares;
  int cmp_count;
  int low_cnt;

  smrf_top #(.MAKER_VALUE(MAKER), .REVISION_ONE_VALUE(REV1), .REVISION_TWO_VALUE(REV2)) dut (
    .clk(clk), .srst(srst), .cke(cke), .cmd(cmd), .info_flags(info_flags),
    .geometry(geometry), .osc_count_lo(osc_lo), .osc_count_hi(osc_hi),
    .refresh_status(refresh_status), .rsp(rsp), .cfg(cfg), .dq_out(dq_out), .dq_oe(dq_oe));
  smrf_ctrl_model ctrl (.clk(clk), .cmd(cmd), .cke(cke));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // checking and verdict
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // expectations
  // ------------------------------------------------------------
  function automatic smrf_class_type cls(input logic [5:0] a);
    case (a)
      6'h00, 6'h05, 6'h06, 6'h07, 6'h08, 6'h12, 6'h13: return SMRF_CLS_RO;
      6'h04, 6'h0c, 6'h0e: return SMRF_CLS_RW;
      default: return (a <= `SMRF_ADDR_LAST) ? SMRF_CLS_WO : SMRF_CLS_NONE;
    endcase
  endfunction

  function automatic logic [7:0] legal(input logic [5:0] a, input logic [7:0] d);
    case (a)
      6'h0a: return d & `SMRF_IMP_CAL_MASK;
      6'h0b: return d & `SMRF_TERM_MASK;
      6'h0c, 6'h0e: return d & `SMRF_REF_LEVEL_MASK;
      6'h15: return 8'h00;
      default: return d;
    endcase
  endfunction

  function automatic logic [7:0] exp_read(input logic [5:0] a);
    case (a)
      6'h00: return {3'h0, info_flags};
      6'h04: return {refresh_status[7], shadow[4][6:3], refresh_status[2:0]};
      6'h05: return MAKER;
      6'h06: return REV1;
      6'h07: return REV2;
      6'h08: return geometry;
      6'h0c, 6'h0e: return shadow[a];
      6'h12: return osc_lo;
      6'h13: return osc_hi;
      default: return `SMRF_UNDEF_READ;
    endcase
  endfunction

  function automatic smrf_cfg_type exp_cfg();
    smrf_cfg_type c;
    c = '0;
    c.burst_preamble = shadow[1];
    c.latency = shadow[2];
    c.refresh = shadow[4];
    c.io = shadow[3];
    c.cmd_termination = {1'b0, shadow[11][6:4]};
    c.data_termination = {1'b0, shadow[11][2:0]};
    c.set_point = shadow[13];
    c.low_byte_invert = shadow[15];
    c.high_byte_invert = shadow[20];
    c.write_leveling = shadow[2][7];
    return c;
  endfunction

  // ------------------------------------------------------------
  // command tasks
  // ------------------------------------------------------------
  task automatic upd(input logic [5:0] a, input logic [7:0] d);
    if (cls(a) inside {SMRF_CLS_WO, SMRF_CLS_RW}) begin
      shadow[a] = d;
    end
  endtask

  task automatic mrw(input logic [5:0] a, input logic [7:0] d);
    ctrl.issue(1'b0, 1'b1, a, legal(a, d), 1);
    upd(a, legal(a, d));
    @(negedge clk);
    cfg_seen = cfg;
    check("cfg", cfg_seen, exp_cfg());
  endtask

  task automatic mrr(input logic [5:0] a, input int n, input logic both, input logic [7:0] d);
    ctrl.issue(1'b1, both, a, d, n);
    if (both) begin
      upd(a, legal(a, d));
    end
    repeat (2 - n) @(negedge clk);
    check("rsp_valid", rsp.valid, !both);
    if (!both) begin
      check("rsp_data", rsp.data, exp_read(a));
      check("dq_oe", dq_oe, cke);
      if (cke) begin
        check("dq_out", dq_out, exp_read(a));
      end
    end
    @(negedge clk);
    check("rsp_after", rsp.valid, 1'b0);
  endtask

  // outputs stay released while clock enable is low
  always @(negedge clk) begin
    low_cnt <= cke ? 0 : low_cnt + 1;
    if (low_cnt > 4) begin
      check("dq_oe_low", dq_oe, 1'b0);
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    srst = 1'b1;
    info_flags = '0;
    geometry = '0;
    osc_lo = '0;
    osc_hi = '0;
    refresh_status = '0;
    miscompares = 0;
    cmp_count = 0;
    low_cnt = 0;
    for (int i = 0; i < 64; i++) begin
      shadow[i] = 8'h00;
    end
    void'($urandom(32'hbcc3));
    repeat (16) @(negedge clk);
    srst = 1'b0;
    check("rsp_reset", rsp, '0);
    check("cfg_reset", cfg, '0);
    ctrl.set_cke(1'b1);
    repeat (3) @(negedge clk);
    for (int a = 0; a < 26; a++) begin
      mrw(a[5:0], 8'($urandom()));
    end
    mrw(6'h02, 8'h80);
    mrw(6'h02, 8'h00);
    mrr(6'h0c, 2, 1'b0, 8'h00);
    mrr(6'h0e, 1, 1'b1, 8'h15);
    mrr(6'h0e, 1, 1'b0, 8'h00);
    mrr(6'h3f, 1, 1'b0, 8'h00);
    for (int i = 0; i < 400; i++) begin
      info_flags = 5'($urandom());
      geometry = 8'($urandom());
      osc_lo = 8'($urandom());
      osc_hi = 8'($urandom());
      refresh_status = 8'($urandom());
      ra = 6'($urandom_range(0, 27));
      if ($urandom_range(0, 1) == 1) begin
        mrw(ra, 8'($urandom()));
      end else begin
        mrr(ra, 1, 1'b0, 8'h00);
      end
    end
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < 64; i++) begin
      shadow[i] = 8'h00;
    end
    check("cfg_rerst", cfg, '0);
    repeat (3) @(negedge clk);
    mrr(6'h0c, 1, 1'b0, 8'h00);
    ctrl.set_cke(1'b0);
    repeat (6) @(negedge clk);
    for (int a = 0; a < 24; a++) begin
      mrr(a[5:0], 1, 1'b0, 8'h00);
    end
    give_verdict();
  end

  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end
endmodule
